//--- hw/smrb_bank.sv
// Purpose: System misc register bank: scratch words, id words, pull-up and clock-out control
// Assumes: i_rst_n is the power-on reset; i_sys_rst_n is a synchronous system reset on i_clock
// Notes:   Clock outputs are combinational muxes of the supplied clocks
`timescale 1ns/1ps
`include "smrb_map.svh"

module smrb_bank #(
  parameter logic [15:0] ID_HIGH = 16'h0a5a,                  // Arbitrary value
  parameter logic [15:0] ID_LOW  = 16'h5a0a                   // Arbitrary value
) (
  input  wire logic                         i_clock,          // Bank clock
  input  wire logic                         i_rst_n,          // Power-on reset
  input  wire logic                         i_sys_rst_n,      // Pin, software or watchdog reset
  input  wire logic                         i_clk_en,         // Freezes all state when low
  input  wire logic [3:0]                   i_addr,           // Register word index
  input  wire logic [15:0]                  i_wdata,          // Write data
  input  wire logic                         i_wr,             // Write strobe
  input  wire logic                         i_rd,             // Read strobe
  output logic      [15:0]                  o_rdata,          // Read data, cycle after i_rd
  input  wire logic [`SMRB_SRC_COUNT-1:0]   i_clock_sources,  // Clocks indexed by select code
  input  wire logic [3:0]                   i_port_b_peripheral_enable, // Pins 7..4 peripheral mode
  input  wire logic [3:0]                   i_addr_hi,        // Address bits 23..20
  output logic      [3:0]                   o_pb_peripheral_out, // Pins 7..4 peripheral output
  output logic                              o_clock_out_pin,  // Clock-out pin value
  output logic                              o_clock_out_oe_n, // Clock-out enable, low drives
  output smrb_pkg::smrb_pullup_s            o_pullup_disable  // Group pull-up disables
);

  ////////////////////////////////////////////////////////////////////////////////
  // Write decode
  logic                 hit_wr_pullup;
  logic                 hit_wr_clkout;
  logic [3:0]           hit_wr_scratch;

  always_comb
  begin
    hit_wr_pullup  = i_wr && (i_addr == `SMRB_OFS_PULLUP);
    hit_wr_clkout  = i_wr && (i_addr == `SMRB_OFS_CLKOUT);
    hit_wr_scratch = 4'h0;
    if (i_wr && (i_addr == `SMRB_OFS_SCRATCH0))
    begin
      hit_wr_scratch = 4'h1;
    end
    else if (i_wr && (i_addr == `SMRB_OFS_SCRATCH1))
    begin
      hit_wr_scratch = 4'h2;
    end
    else if (i_wr && (i_addr == `SMRB_OFS_SCRATCH2))
    begin
      hit_wr_scratch = 4'h4;
    end
    else if (i_wr && (i_addr == `SMRB_OFS_SCRATCH3))
    begin
      hit_wr_scratch = 4'h8;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Scratch words, cleared by power-on reset only
  smrb_pkg::smrb_word_t scratch_q [4];
  smrb_pkg::smrb_word_t scratch_d [4];

  always_comb
  begin
    for (int k = 0; k < 4; k++)
    begin
      scratch_d[k] = hit_wr_scratch[k] ? i_wdata : scratch_q[k];
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      for (int k = 0; k < 4; k++)
      begin
        scratch_q[k] <= `SMRB_SCRATCH_RESET;
      end
    end
    else if (i_clk_en)
    begin
      for (int k = 0; k < 4; k++)
      begin
        scratch_q[k] <= scratch_d[k];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers, loaded with their reset values by every reset
  smrb_pkg::smrb_word_t pullup_q;
  smrb_pkg::smrb_word_t pullup_d;
  smrb_pkg::smrb_word_t clkout_q;
  smrb_pkg::smrb_word_t clkout_d;

  always_comb
  begin
    pullup_d = pullup_q;
    clkout_d = clkout_q;
    if (!i_sys_rst_n)
    begin
      pullup_d = `SMRB_PULLUP_RESET;
      clkout_d = `SMRB_CLKOUT_RESET;
    end
    else
    begin
      if (hit_wr_pullup)
      begin
        pullup_d = i_wdata & `SMRB_PULLUP_MASK;
      end
      if (hit_wr_clkout)
      begin
        clkout_d = i_wdata & `SMRB_CLKOUT_MASK;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pullup_q <= `SMRB_PULLUP_RESET;
      clkout_q <= `SMRB_CLKOUT_RESET;
    end
    else if (i_clk_en)
    begin
      pullup_q <= pullup_d;
      clkout_q <= clkout_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read path, id words are constants and never written
  smrb_pkg::smrb_word_t rdata_q;
  smrb_pkg::smrb_word_t rdata_d;

  always_comb
  begin
    rdata_d = `SMRB_ZERO_WORD;
    if (!i_rd)
    begin
      rdata_d = `SMRB_ZERO_WORD;
    end
    else if (i_addr == `SMRB_OFS_SCRATCH0)
    begin
      rdata_d = scratch_q[0];
    end
    else if (i_addr == `SMRB_OFS_SCRATCH1)
    begin
      rdata_d = scratch_q[1];
    end
    else if (i_addr == `SMRB_OFS_SCRATCH2)
    begin
      rdata_d = scratch_q[2];
    end
    else if (i_addr == `SMRB_OFS_SCRATCH3)
    begin
      rdata_d = scratch_q[3];
    end
    else if (i_addr == `SMRB_OFS_ID_HIGH)
    begin
      rdata_d = ID_HIGH;
    end
    else if (i_addr == `SMRB_OFS_ID_LOW)
    begin
      rdata_d = ID_LOW;
    end
    else if (i_addr == `SMRB_OFS_PULLUP)
    begin
      rdata_d = pullup_q & `SMRB_PULLUP_MASK;
    end
    else if (i_addr == `SMRB_OFS_CLKOUT)
    begin
      rdata_d = clkout_q & `SMRB_CLKOUT_MASK;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rdata_q <= `SMRB_ZERO_WORD;
    end
    else if (i_clk_en)
    begin
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Pull-up group outputs
  always_comb
  begin
    o_pullup_disable.fault_a3    = pullup_q[`SMRB_PU_FAULT_A3];
    o_pullup_disable.can_rx      = pullup_q[`SMRB_PU_CAN_RX];
    o_pullup_disable.mem_mode    = pullup_q[`SMRB_PU_MEM_MODE];
    o_pullup_disable.reset_pin   = pullup_q[`SMRB_PU_RESET_PIN];
    o_pullup_disable.irq_pins    = pullup_q[`SMRB_PU_IRQ_PINS];
    o_pullup_disable.boot_pin    = pullup_q[`SMRB_PU_BOOT_PIN];
    o_pullup_disable.fault_b     = pullup_q[`SMRB_PU_FAULT_B];
    o_pullup_disable.fault_a012  = pullup_q[`SMRB_PU_FAULT_A012];
    o_pullup_disable.bus_strobes = pullup_q[`SMRB_PU_BUS_STROBES];
    o_pullup_disable.scan_pins   = pullup_q[`SMRB_PU_SCAN_PINS];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Clock-out mux and port-B alternate clocks
  smrb_pkg::smrb_clkout_s clkout_f;
  logic [3:0]             pb_alt_clock;

  always_comb
  begin
    clkout_f = smrb_pkg::smrb_clkout_s'(clkout_q);
    // Codes above the last source drive low
    if (clkout_f.clock_out_source <= `SMRB_SRC_CONV_B)
    begin
      o_clock_out_pin = i_clock_sources[clkout_f.clock_out_source];
    end
    else
    begin
      o_clock_out_pin = 1'b0;
    end
    o_clock_out_oe_n = clkout_f.clock_out_disable;
    pb_alt_clock = {i_clock_sources[`SMRB_SRC_OSC],
                    i_clock_sources[`SMRB_SRC_SYSCLK2],
                    i_clock_sources[`SMRB_SRC_SYSTEM],
                    i_clock_sources[`SMRB_SRC_PRESCALER]};
    for (int k = 0; k < 4; k++)
    begin
      if (!i_port_b_peripheral_enable[k])
      begin
        o_pb_peripheral_out[k] = 1'b0;
      end
      else if (clkout_f.pb_alt_select[k])
      begin
        o_pb_peripheral_out[k] = pb_alt_clock[k];
      end
      else
      begin
        o_pb_peripheral_out[k] = i_addr_hi[k];
      end
    end
  end

endmodule // smrb_bank

//--- hw/smrb_map.svh
// Purpose: Offsets, field positions and reset values of the system misc register bank
// Assumes: 16-bit registers addressed by word index on a plain strobe port
// Notes:   Included by the bank top, the port checker and the bench
//
// Contract
// - Four 16-bit scratch words clear only on power-on reset, no hardware function.
// - Upper id register returns fixed upper 16 bits of scan id; writes ignored.
// - Lower id register returns fixed lower 16 bits, constant from reset; writes ignored.
// - Pull-up disable bit 1 turns off group pull-ups; resets to zero.
// - Bit 14 fault A3, bit 13 CAN receive, bit 12 memory mode input.
// - Bit 11 reset, 10 interrupts, 9 boot, 8 fault B, 7 faults A0-A2.
// - Bit 5 bus write/read strobes, bit 3 scan reset, mode and data-in pins.
// - Reserved bits read zero and ignore writes.
// - Clock-out disable low drives selected clock, high floats pin; resets to one.
// - Select codes 0, 7, 8, 11, 13, 17 route main clocks; field resets to zero.
// - Codes 1 through 6 route internal test clocks.
// - Bit 9 puts oscillator on pin B7, bit 8 secondary system clock on B6.
// - Bit 7 puts system clock on pin B5, bit 6 prescaler clock on B4.
// - Alternate bits act only in peripheral mode; zero selects address lines.
`ifndef SMRB_MAP_SVH
`define SMRB_MAP_SVH

// Register word offsets
`define SMRB_OFS_SCRATCH0     4'h2
`define SMRB_OFS_SCRATCH1     4'h3
`define SMRB_OFS_SCRATCH2     4'h4
`define SMRB_OFS_SCRATCH3     4'h5
`define SMRB_OFS_ID_HIGH      4'h6
`define SMRB_OFS_ID_LOW       4'h7
`define SMRB_OFS_PULLUP       4'h8
`define SMRB_OFS_CLKOUT       4'ha

// Writable-bit masks and reset values
`define SMRB_PULLUP_MASK      16'h7fa8
`define SMRB_PULLUP_RESET     16'h0000
`define SMRB_CLKOUT_MASK      16'h03ff
`define SMRB_CLKOUT_RESET     16'h0020
`define SMRB_SCRATCH_RESET    16'h0000
`define SMRB_ZERO_WORD        16'h0000

// Pull-up group bit positions
`define SMRB_PU_FAULT_A3      14
`define SMRB_PU_CAN_RX        13
`define SMRB_PU_MEM_MODE      12
`define SMRB_PU_RESET_PIN     11
`define SMRB_PU_IRQ_PINS      10
`define SMRB_PU_BOOT_PIN      9
`define SMRB_PU_FAULT_B       8
`define SMRB_PU_FAULT_A012    7
`define SMRB_PU_BUS_STROBES   5
`define SMRB_PU_SCAN_PINS     3

// Clock-out source codes
`define SMRB_SRC_SYSTEM       5'h00
`define SMRB_SRC_OSC          5'h07
`define SMRB_SRC_PLL          5'h08
`define SMRB_SRC_SYSCLK2      5'h0d
`define SMRB_SRC_PRESCALER    5'h0b
`define SMRB_SRC_CONV_B       5'h11
`define SMRB_SRC_COUNT        18

`endif

//--- hw/smrb_pkg.sv
// Purpose: Types of the system misc register bank
// Assumes: Constants live in smrb_map.svh
// Notes:   Field order of the struct matches the clock-out register bits
package smrb_pkg;

  typedef logic [15:0] smrb_word_t;

  typedef struct packed {
    logic [5:0] reserved;
    logic [3:0] pb_alt_select;     // [3]=pb7 .. [0]=pb4
    logic       clock_out_disable;
    logic [4:0] clock_out_source;
  } smrb_clkout_s;

  typedef struct packed {
    logic       fault_a3;
    logic       can_rx;
    logic       mem_mode;
    logic       reset_pin;
    logic       irq_pins;
    logic       boot_pin;
    logic       fault_b;
    logic       fault_a012;
    logic       bus_strobes;
    logic       scan_pins;
  } smrb_pullup_s;

endpackage

//--- sim/smrb_bank_monitor.sv
// Purpose: Port checker for the system misc register bank
// Assumes: One clock; i_rst_n is power-on reset
// Notes:   Shadows the clock-out word to predict pin muxes
`timescale 1ns/1ps
`include "smrb_map.svh"

module smrb_bank_monitor #(
  parameter logic [15:0] ID_HIGH = 16'h0a5a, // Arbitrary value
  parameter logic [15:0] ID_LOW  = 16'h5a0a  // Arbitrary value
) (
  input wire logic                       i_clock,                    // Clock
  input wire logic                       i_rst_n,                    // POR
  input wire logic                       i_sys_rst_n,                // Sys reset
  input wire logic                       i_clk_en,                   // Enable
  input wire logic [3:0]                 i_addr,                     // Index
  input wire logic [15:0]                i_wdata,                    // Data
  input wire logic                       i_wr,                       // Write
  input wire logic                       i_rd,                       // Read
  input wire logic [15:0]                o_rdata,                    // Read data
  input wire logic [`SMRB_SRC_COUNT-1:0] i_clock_sources,            // Clocks
  input wire logic [3:0]                 i_port_b_peripheral_enable, // Mode
  input wire logic [3:0]                 i_addr_hi,                  // Address
  input wire logic [3:0]                 o_pb_peripheral_out,        // Port B
  input wire logic                       o_clock_out_pin,            // Pin
  input wire logic                       o_clock_out_oe_n,           // Enable
  input wire smrb_pkg::smrb_pullup_s     o_pullup_disable            // Pull-ups
);
  logic [9:0] clk_q;
  logic [9:0] clk_d;
  logic [9:0] pu_w;
  logic [3:0] pb_exp;
  logic       pin_exp;
  logic       wr_ok;
  assign wr_ok = i_clk_en && i_wr && i_sys_rst_n;
  assign pu_w = {i_wdata[14:7], i_wdata[5], i_wdata[3]};
  assign pin_exp = (clk_q[4:0] < 5'h12) ? i_clock_sources[clk_q[4:0]] : 1'b0;
  assign pb_exp = i_port_b_peripheral_enable & ((clk_q[9:6] & {i_clock_sources[7], i_clock_sources[13],
    i_clock_sources[0], i_clock_sources[11]}) | (~clk_q[9:6] & i_addr_hi));
  always_comb
  begin
    clk_d = clk_q;
    if (i_clk_en && !i_sys_rst_n)
      clk_d = 10'h020;
    else if (wr_ok && i_addr == `SMRB_OFS_CLKOUT)
      clk_d = i_wdata[9:0];
  end
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      clk_q <= 10'h020;
    else
      clk_q <= clk_d;
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);
  property p_id_high;
    i_clk_en && i_rd && i_addr == 4'h6 |=> o_rdata == ID_HIGH;
  endproperty
  a_id_high: assert property (p_id_high) else $error("id high read wrong");
  property p_id_low;
    i_clk_en && i_rd && i_addr == 4'h7 |=> o_rdata == ID_LOW;
  endproperty
  a_id_low: assert property (p_id_low) else $error("id low read wrong");
  property p_rd_idle;
    i_clk_en && !i_rd |=> o_rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_pu_rsvd;
    i_clk_en && i_rd && i_addr == 4'h8 |=> (o_rdata & 16'h8057) == 16'h0000;
  endproperty
  a_pu_rsvd: assert property (p_pu_rsvd) else $error("reserved pull-up bit set");
  property p_pu_write;
    wr_ok && i_addr == 4'h8 |=> o_pullup_disable == $past(pu_w);
  endproperty
  a_pu_write: assert property (p_pu_write) else $error("pull-up outputs wrong");
  property p_sys_rst;
    i_clk_en && !i_sys_rst_n |=> o_pullup_disable == 10'h000 && o_clock_out_oe_n;
  endproperty
  a_sys_rst: assert property (p_sys_rst) else $error("control reset wrong");
  property p_oe;
    o_clock_out_oe_n == clk_q[5];
  endproperty
  a_oe: assert property (p_oe) else $error("clock-out enable wrong");
  property p_pin;
    !o_clock_out_oe_n |-> o_clock_out_pin == pin_exp;
  endproperty
  a_pin: assert property (p_pin) else $error("clock-out source wrong");
  property p_pb;
    o_pb_peripheral_out == pb_exp;
  endproperty
  a_pb: assert property (p_pb) else $error("port b output wrong");
  c_sys_rst: cover property (i_clk_en && !i_sys_rst_n);
  c_drive: cover property (!o_clock_out_oe_n && o_clock_out_pin);
  c_pb: cover property (o_pb_peripheral_out != 4'h0);
endmodule // smrb_bank_monitor

bind smrb_bank smrb_bank_monitor #(.ID_HIGH(ID_HIGH), .ID_LOW(ID_LOW)) u_mon (
  .i_clock(i_clock), .i_rst_n(i_rst_n), .i_sys_rst_n(i_sys_rst_n), .i_clk_en(i_clk_en),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_clock_sources(i_clock_sources), .i_port_b_peripheral_enable(i_port_b_peripheral_enable),
  .i_addr_hi(i_addr_hi), .o_pb_peripheral_out(o_pb_peripheral_out), .o_clock_out_pin(o_clock_out_pin),
  .o_clock_out_oe_n(o_clock_out_oe_n), .o_pullup_disable(o_pullup_disable));

//--- sim/smrb_bank_tb.sv
// Purpose: Register-level bench for the system misc register bank
// Assumes: Read data stand only in the cycle after the read strobe
// Notes:   Array m mirrors every register word
`timescale 1ns/1ps
`include "smrb_map.svh"

module smrb_bank_tb;
  localparam logic [15:0] IDH = 16'h3c3c; // Arbitrary value
  localparam logic [15:0] IDL = 16'hc3c3; // Arbitrary value
  logic                       i_clock, i_rst_n, i_sys_rst_n, i_clk_en, i_wr, i_rd;
  logic                       o_clock_out_pin, o_clock_out_oe_n;
  logic [3:0]                 i_addr, i_port_b_peripheral_enable, i_addr_hi, o_pb_peripheral_out;
  logic [15:0]                i_wdata, o_rdata;
  logic [`SMRB_SRC_COUNT-1:0] i_clock_sources;
  smrb_pkg::smrb_pullup_s     o_pullup_disable;
  logic [15:0]                m [16];
  int                         n_fail, check_count;

  smrb_bank #(.ID_HIGH(IDH), .ID_LOW(IDL)) dut (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_sys_rst_n(i_sys_rst_n), .i_clk_en(i_clk_en), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_clock_sources(i_clock_sources),
    .i_port_b_peripheral_enable(i_port_b_peripheral_enable), .i_addr_hi(i_addr_hi),
    .o_pb_peripheral_out(o_pb_peripheral_out), .o_clock_out_pin(o_clock_out_pin),
    .o_clock_out_oe_n(o_clock_out_oe_n), .o_pullup_disable(o_pullup_disable));
  ////////////////////////////////////////////////////////////
  function automatic logic [15:0] wmask(input logic [3:0] a);
    case (a)
      4'h2, 4'h3, 4'h4, 4'h5: return 16'hffff;
      4'h8: return 16'h7fa8;
      4'ha: return 16'h03ff;
      default: return 16'h0000;
    endcase
  endfunction
  task automatic por_model();
    for (int a = 0; a < 16; a++)
      m[a] = 16'h0000;
    m[6] = IDH;
    m[7] = IDL;
    m[10] = 16'h0020;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    if (i_clk_en)
      m[a] = (m[a] & ~wmask(a)) | (d & wmask(a));
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task automatic rd_all();
    for (int a = 0; a < 16; a++)
    begin
      @(posedge i_clock);
      i_rd <= 1'b1;
      i_addr <= a[3:0];
      @(posedge i_clock);
      i_rd <= 1'b0;
      #1 check("rdata", o_rdata, m[a]);
    end
    check("pullup", {6'h0, o_pullup_disable}, {6'h0, m[8][14:7], m[8][5], m[8][3]});
    check("oe_n", {15'h0, o_clock_out_oe_n}, {15'h0, m[10][5]});
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end
  initial
  begin
    #2000000;
    n_fail++;
    give_verdict();
  end
  initial
  begin
    {i_rst_n, i_wr, i_rd, i_addr, i_wdata, i_clock_sources, i_port_b_peripheral_enable, i_addr_hi} = '0;
    i_sys_rst_n = 1'b1;
    i_clk_en = 1'b1;
    n_fail = 0;
    check_count = 0;
    por_model();
    repeat (20) @(posedge i_clock);
    i_rst_n <= 1'b1;
    rd_all();
    for (int a = 0; a < 16; a++)
      wr(a[3:0], 16'hffff);
    rd_all();
    for (int a = 0; a < 16; a++)
      wr(a[3:0], 16'h5a5a ^ {a[3:0], 12'h000});
    rd_all();
    wr(4'h8, 16'h1200);
    #1 check("pwrsave", {14'h0, o_pullup_disable.mem_mode, o_pullup_disable.boot_pin}, 16'h0003);
    for (int c = 0; c < 32; c++)
    begin
      wr(4'ha, {11'h000, c[4:0]});
      i_clock_sources <= 18'h00001 << c;
      #1 check("clkpin", {15'h0, o_clock_out_pin}, (c < 18) ? 16'h0001 : 16'h0000);
      check("oe_n", {15'h0, o_clock_out_oe_n}, 16'h0000);
    end
    i_clock_sources <= 18'h00081;
    i_addr_hi <= 4'h5;
    for (int i = 0; i < 32; i++)
    begin
      i_port_b_peripheral_enable <= i[4] ? 4'hf : 4'h6;
      wr(4'ha, {6'h00, i[3:0], 6'h20});
      #1 check("portb", {12'h0, o_pb_peripheral_out},
        {12'h0, (i[4] ? 4'hf : 4'h6) & ((i[3:0] & 4'ha) | (~i[3:0] & 4'h5))});
    end
    wr(4'h8, 16'hffff);
    @(posedge i_clock);
    i_sys_rst_n <= 1'b0;
    i_wr <= 1'b1;
    i_addr <= 4'h8;
    i_wdata <= 16'h7fa8;
    @(posedge i_clock);
    i_sys_rst_n <= 1'b1;
    i_wr <= 1'b0;
    m[8] = 16'h0000;
    m[10] = 16'h0020;
    rd_all();
    i_clk_en <= 1'b0;
    wr(4'h2, 16'hdead);
    i_clk_en <= 1'b1;
    rd_all();
    i_rst_n <= 1'b0;
    repeat (3) @(posedge i_clock);
    i_rst_n <= 1'b1;
    por_model();
    rd_all();
    give_verdict();
  end
endmodule // smrb_bank_tb
